// file: tbd_defs.vh
`ifndef TBD_DEFS_VH
`define TBD_DEFS_VH
`define TBD_AW 20
`define TBD_A_CMD 20'h0_0000
`define TBD_A_CAT 20'h0_0004
`define TBD_A_DIR 20'h0_0008
`define TBD_A_GRAN 20'h0_000c
`define TBD_A_PTR 20'h0_0010
`define TBD_A_OFFS 20'h0_0014
`define TBD_A_LEN 20'h0_0018
`define TBD_A_MODE 20'h0_001c
`define TBD_A_MSIZE 20'h0_0020
`define TBD_A_STAT 20'h0_0024
`define TBD_A_DONE 20'h0_0028
`define TBD_A_TADDR 20'h0_002c
`define TBD_A_TDATA 20'h0_0030
`define TBD_A_MTEST 20'h3_0ffc
`define TBD_CAT_DATA 16'h03e8
`define TBD_CAT_SLOW 16'h07d0
`define TBD_CAT_TSTAMP 16'h0bb8
`define TBD_IDX_DATA 2'h0
`define TBD_IDX_SLOW 2'h1
`define TBD_IDX_TSTAMP 2'h2
`define TBD_IDX_NONE 2'h3
`define TBD_DIR_H2B 2'h0
`define TBD_DIR_B2H 2'h1
`define TBD_DIR_B2G 2'h2
`define TBD_DIR_G2B 2'h3
`define TBD_KIND_ANALOG 2'h0
`define TBD_KIND_DIGITAL 2'h1
`define TBD_KIND_GEN 2'h2
`define TBD_CMD_DEFINE 0
`define TBD_CMD_START 1
`define TBD_CMD_INVAL 2
`define TBD_MODE_GEN 0
`define TBD_MODE_FIFO 1
`define TBD_ST_BUSY 0
`define TBD_ST_VALID_LSB 4
`define TBD_ST_BLOCK 8
`define TBD_ST_END 9
`define TBD_ST_ERR 11
`define TBD_GRAN_MIN 32'h0000_0010
`define TBD_GRAN_2K 32'h0000_0800
`define TBD_PAGE_MASK 32'h0000_0fff
`define TBD_WORD_BYTES 32'h0000_0004
`define TBD_ZERO 32'h0000_0000
`endif

// file: tbd_gran_check.v
`timescale 1ns/10ps
`include "tbd_defs.vh"
module tbd_gran_check (
  input wire [1:0] cat_idx_i,
  input wire [31:0] gran_i,
  output reg ok_o
);
  reg zero;
  reg page;
  reg frac;
  always @* begin
    zero = (gran_i == `TBD_ZERO);
    page = ((gran_i & `TBD_PAGE_MASK) == `TBD_ZERO);
    frac = ((gran_i & (gran_i - `TBD_GRAN_MIN / `TBD_GRAN_MIN)) == `TBD_ZERO) &&
      (gran_i >= `TBD_GRAN_MIN) && (gran_i <= `TBD_GRAN_2K);
    if (cat_idx_i == `TBD_IDX_DATA) begin
      ok_o = zero || page || frac;
    end else begin
      // Only 2k and whole pages reach the 2k floor
      ok_o = zero || page || (gran_i == `TBD_GRAN_2K);
    end
  end
endmodule // tbd_gran_check

// file: tbd_block_counter.v
`timescale 1ns/10ps
`include "tbd_defs.vh"
module tbd_block_counter (
  input wire clk_i,
  input wire rst_i,
  input wire clear_i,
  input wire step_i,
  input wire [31:0] gran_i,
  output wire block_o
);
  reg [31:0] cnt_reg;
  wire [31:0] cnt_inc;
  assign cnt_inc = cnt_reg + `TBD_WORD_BYTES;
  // One pulse per full notify block moved
  assign block_o = step_i && (gran_i != `TBD_ZERO) && (cnt_inc == gran_i);
  always @(posedge clk_i) begin
    if (rst_i || clear_i) begin
      cnt_reg <= `TBD_ZERO;
    end else if (step_i) begin
      if (block_o) begin
        cnt_reg <= `TBD_ZERO;
      end else begin
        cnt_reg <= cnt_inc;
      end
    end
  end
endmodule // tbd_block_counter

// file: tbd_dma_setup.v
`timescale 1ns/10ps
`include "tbd_defs.vh"
// What this block does
// - Category codes 1000, 2000, 3000 select sample, slow channel, timestamp.
// - Direction 0 host-to-board, 1 board-to-host, 2/3 GPU needing option.
// - Direction must suit mode: acquisition refuses host-to-board, generation reverse.
// - Nonzero notify granularity raises an event per granularity bytes moved.
// - Zero granularity runs whole length, one event at completion.
// - Board-to-host overwrites host buffer with board memory contents.
// - Outside FIFO mode transfer starts at programmed board byte offset.
// - Length in bytes; standard mode length never exceeds memory size.
// - Memory test control 1 enters test mode, locking mode and memory size writes; 0 leaves.
// - Test mode gives random board memory access and lifts the mode restriction on direction; GPU directions still need the option.
// - Descriptor invalidated by the invalidate command on its category, by its start, or by transfer completion.
// - Slow channel only on analog acquisition; timestamp on acquisition boards.
// - Block-ready flag per notify block; end flag only for zero granularity.
// - Each defined buffer serves exactly one transfer and is invalidated when that transfer starts.
module tbd_dma_setup #(
  parameter [1:0] BOARD_KIND = `TBD_KIND_ANALOG,
  parameter GPU_OPTION = 1'b0
) (
  input wire CLOCK_I,
  input wire RST_I,
  input wire [19:0] ADDR_I,
  input wire [31:0] WDATA_I,
  input wire WR_I,
  input wire RD_I,
  output reg [31:0] RDATA_O,
  output reg [31:0] BMEM_ADDR_O,
  output reg BMEM_RE_O,
  output reg BMEM_WE_O,
  output reg [31:0] BMEM_WDATA_O,
  input wire [31:0] BMEM_RDATA_I,
  output reg [31:0] HOST_ADDR_O,
  output reg HOST_RE_O,
  output reg HOST_WE_O,
  output reg [31:0] HOST_WDATA_O,
  input wire [31:0] HOST_RDATA_I,
  output reg GPU_SEL_O,
  output reg BUSY_O,
  output reg BLOCK_O,
  output reg END_O
);
  localparam [1:0] S_IDLE = 2'h0;
  localparam [1:0] S_ISSUE = 2'h1;
  localparam [1:0] S_LATCH = 2'h2;
  localparam [1:0] S_WRITE = 2'h3;

  function [1:0] cat_idx;
    input [15:0] code;
    begin
      case (code)
        `TBD_CAT_DATA: cat_idx = `TBD_IDX_DATA;
        `TBD_CAT_SLOW: cat_idx = `TBD_IDX_SLOW;
        `TBD_CAT_TSTAMP: cat_idx = `TBD_IDX_TSTAMP;
        default: cat_idx = `TBD_IDX_NONE;
      endcase
    end
  endfunction

  function src_is_board;
    input [1:0] d;
    begin
      src_is_board = (d == `TBD_DIR_B2H) || (d == `TBD_DIR_B2G);
    end
  endfunction

  reg [15:0] cat_reg;
  reg [1:0] dir_reg;
  reg [31:0] gran_reg;
  reg [31:0] ptr_reg;
  reg [31:0] offs_reg;
  reg [31:0] len_reg;
  reg [1:0] mode_reg;
  reg [31:0] msize_reg;
  reg mtest_reg;
  reg [31:0] taddr_reg;
  reg [31:0] tdata_reg;
  reg tfetch_reg;
  reg tcatch_reg;
  reg [1:0] d_dir [0:2];
  reg [31:0] d_gran [0:2];
  reg [31:0] d_ptr [0:2];
  reg [31:0] d_offs [0:2];
  reg [31:0] d_len [0:2];
  reg [2:0] valid_reg;
  reg [1:0] state_reg;
  reg [1:0] act_reg;
  reg [1:0] adir_reg;
  reg [31:0] agran_reg;
  reg [31:0] alen_reg;
  reg [31:0] done_reg;
  reg [31:0] baddr_reg;
  reg [31:0] haddr_reg;
  reg blk_flag_reg;
  reg end_flag_reg;
  reg err_flag_reg;

  wire bus_wr_cmd;
  wire [1:0] widx;
  wire gran_ok;
  wire blk_hit;
  wire cat_ok;
  wire dir_ok;
  wire len_ok;
  wire def_ok;
  wire word_done;
  wire last_word;
  wire [31:0] done_inc;
  wire do_define;
  wire do_start;
  wire do_inval;
  wire stat_clr;
  wire start_go;
  reg [31:0] rd_next;

  assign bus_wr_cmd = WR_I && (ADDR_I == `TBD_A_CMD);
  assign widx = cat_idx(cat_reg);
  assign do_define = bus_wr_cmd && WDATA_I[`TBD_CMD_DEFINE];
  assign do_start = bus_wr_cmd && WDATA_I[`TBD_CMD_START];
  assign do_inval = bus_wr_cmd && WDATA_I[`TBD_CMD_INVAL];
  assign stat_clr = WR_I && (ADDR_I == `TBD_A_STAT);
  // Refused starts must leave a running transfer untouched
  assign start_go = do_start && (widx != `TBD_IDX_NONE) && valid_reg[widx] &&
    (state_reg == S_IDLE);

  // Board kind decides which extra categories exist
  assign cat_ok = (widx == `TBD_IDX_DATA) ||
    ((widx == `TBD_IDX_SLOW) && (BOARD_KIND == `TBD_KIND_ANALOG)) ||
    ((widx == `TBD_IDX_TSTAMP) && (BOARD_KIND != `TBD_KIND_GEN));

  // Test mode lifts the mode restriction on direction
  assign dir_ok = (dir_reg[1] ? GPU_OPTION : 1'b1) &&
    (mtest_reg ||
     (mode_reg[`TBD_MODE_GEN] != src_is_board(dir_reg)));

  // FIFO streaming has no fixed memory size bound
  assign len_ok = mode_reg[`TBD_MODE_FIFO] || (len_reg <= msize_reg);
  assign def_ok = cat_ok && dir_ok && gran_ok && len_ok;

  tbd_gran_check u_gran (
    .cat_idx_i(widx),
    .gran_i(gran_reg),
    .ok_o(gran_ok)
  );

  assign word_done = (state_reg == S_WRITE);
  assign done_inc = done_reg + `TBD_WORD_BYTES;
  assign last_word = word_done && (done_inc >= alen_reg);

  tbd_block_counter u_blk (
    .clk_i(CLOCK_I),
    .rst_i(RST_I),
    .clear_i(start_go),
    .step_i(word_done),
    .gran_i(agran_reg),
    .block_o(blk_hit)
  );

  always @(posedge CLOCK_I) begin
    if (RST_I) begin
      cat_reg <= 16'h0000;
      dir_reg <= 2'h0;
      gran_reg <= `TBD_ZERO;
      ptr_reg <= `TBD_ZERO;
      offs_reg <= `TBD_ZERO;
      len_reg <= `TBD_ZERO;
      mode_reg <= 2'h0;
      msize_reg <= `TBD_ZERO;
      mtest_reg <= 1'b0;
      taddr_reg <= `TBD_ZERO;
    end else if (WR_I) begin
      case (ADDR_I)
        `TBD_A_CAT: cat_reg <= WDATA_I[15:0];
        `TBD_A_DIR: dir_reg <= WDATA_I[1:0];
        `TBD_A_GRAN: gran_reg <= WDATA_I;
        `TBD_A_PTR: ptr_reg <= WDATA_I;
        `TBD_A_OFFS: offs_reg <= WDATA_I;
        `TBD_A_LEN: len_reg <= WDATA_I;
        `TBD_A_MODE: begin
          if (!mtest_reg) begin
            mode_reg <= WDATA_I[1:0];
          end
        end
        `TBD_A_MSIZE: begin
          if (!mtest_reg) begin
            msize_reg <= WDATA_I;
          end
        end
        `TBD_A_MTEST: mtest_reg <= WDATA_I[0];
        `TBD_A_TADDR: taddr_reg <= WDATA_I;
        default: begin
        end
      endcase
    end
  end

  // Descriptor store, one slot per category
  always @(posedge CLOCK_I) begin
    if (RST_I) begin
      valid_reg <= 3'h0;
    end else begin
      if (last_word) begin
        valid_reg[act_reg] <= 1'b0;
      end
      if (do_inval && (widx != `TBD_IDX_NONE)) begin
        valid_reg[widx] <= 1'b0;
      end
      if (do_define && def_ok) begin
        // New slot contents replace whatever was defined before
        valid_reg[widx] <= 1'b1;
        d_dir[widx] <= dir_reg;
        d_gran[widx] <= gran_reg;
        d_ptr[widx] <= ptr_reg;
        d_offs[widx] <= offs_reg;
        d_len[widx] <= len_reg;
      end
      if (start_go) begin
        valid_reg[widx] <= 1'b0;
      end
    end
  end

  // Transfer engine, three cycles per word
  always @(posedge CLOCK_I) begin
    if (RST_I) begin
      state_reg <= S_IDLE;
      act_reg <= `TBD_IDX_NONE;
      adir_reg <= 2'h0;
      agran_reg <= `TBD_ZERO;
      alen_reg <= `TBD_ZERO;
      done_reg <= `TBD_ZERO;
      baddr_reg <= `TBD_ZERO;
      haddr_reg <= `TBD_ZERO;
      BMEM_RE_O <= 1'b0;
      BMEM_WE_O <= 1'b0;
      BMEM_WDATA_O <= `TBD_ZERO;
      HOST_RE_O <= 1'b0;
      HOST_WE_O <= 1'b0;
      HOST_WDATA_O <= `TBD_ZERO;
      tfetch_reg <= 1'b0;
      tcatch_reg <= 1'b0;
      tdata_reg <= `TBD_ZERO;
    end else begin
      BMEM_RE_O <= 1'b0;
      BMEM_WE_O <= 1'b0;
      HOST_RE_O <= 1'b0;
      HOST_WE_O <= 1'b0;
      tcatch_reg <= tfetch_reg;
      tfetch_reg <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          if (start_go) begin
            act_reg <= widx;
            adir_reg <= d_dir[widx];
            agran_reg <= d_gran[widx];
            alen_reg <= d_len[widx];
            done_reg <= `TBD_ZERO;
            // Streaming ignores the offset and starts at zero
            baddr_reg <= mode_reg[`TBD_MODE_FIFO] ? `TBD_ZERO : d_offs[widx];
            haddr_reg <= d_ptr[widx];
            if (d_len[widx] == `TBD_ZERO) begin
              state_reg <= S_IDLE;
            end else begin
              state_reg <= S_ISSUE;
              BMEM_RE_O <= src_is_board(d_dir[widx]);
              HOST_RE_O <= !src_is_board(d_dir[widx]);
            end
          end else if (mtest_reg && WR_I && (ADDR_I == `TBD_A_TDATA)) begin
            BMEM_WE_O <= 1'b1;
            BMEM_WDATA_O <= WDATA_I;
          end else if (mtest_reg && WR_I && (ADDR_I == `TBD_A_TADDR)) begin
            BMEM_RE_O <= 1'b1;
            tfetch_reg <= 1'b1;
          end
        end
        S_ISSUE: begin
          state_reg <= S_LATCH;
        end
        S_LATCH: begin
          state_reg <= S_WRITE;
          if (src_is_board(adir_reg)) begin
            HOST_WE_O <= 1'b1;
            HOST_WDATA_O <= BMEM_RDATA_I;
          end else begin
            BMEM_WE_O <= 1'b1;
            BMEM_WDATA_O <= HOST_RDATA_I;
          end
        end
        S_WRITE: begin
          done_reg <= done_inc;
          baddr_reg <= baddr_reg + `TBD_WORD_BYTES;
          haddr_reg <= haddr_reg + `TBD_WORD_BYTES;
          if (last_word) begin
            state_reg <= S_IDLE;
          end else begin
            state_reg <= S_ISSUE;
            BMEM_RE_O <= src_is_board(adir_reg);
            HOST_RE_O <= !src_is_board(adir_reg);
          end
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
      // Redefinition or invalidation of the running slot aborts it
      if ((state_reg != S_IDLE) && (widx == act_reg) &&
          ((do_define && def_ok) || do_inval)) begin
        state_reg <= S_IDLE;
        BMEM_RE_O <= 1'b0;
        BMEM_WE_O <= 1'b0;
        HOST_RE_O <= 1'b0;
        HOST_WE_O <= 1'b0;
      end
      if (tcatch_reg) begin
        tdata_reg <= BMEM_RDATA_I;
      end
    end
  end

  always @(posedge CLOCK_I) begin
    if (RST_I) begin
      BMEM_ADDR_O <= `TBD_ZERO;
      HOST_ADDR_O <= `TBD_ZERO;
      GPU_SEL_O <= 1'b0;
      BUSY_O <= 1'b0;
    end else begin
      // Addresses update no later than the strobes so each access sees its own word
      if (start_go) begin
        BMEM_ADDR_O <= mode_reg[`TBD_MODE_FIFO] ? `TBD_ZERO : d_offs[widx];
        HOST_ADDR_O <= d_ptr[widx];
      end else if (state_reg == S_WRITE) begin
        BMEM_ADDR_O <= baddr_reg + `TBD_WORD_BYTES;
        HOST_ADDR_O <= haddr_reg + `TBD_WORD_BYTES;
      end else if (state_reg != S_IDLE) begin
        BMEM_ADDR_O <= baddr_reg;
        HOST_ADDR_O <= haddr_reg;
      end else if (WR_I && (ADDR_I == `TBD_A_TADDR)) begin
        BMEM_ADDR_O <= WDATA_I;
      end else begin
        BMEM_ADDR_O <= taddr_reg;
      end
      GPU_SEL_O <= adir_reg[1];
      BUSY_O <= (state_reg != S_IDLE);
    end
  end

  // Sticky flags; a new event beats a clear in the same cycle
  always @(posedge CLOCK_I) begin
    if (RST_I) begin
      blk_flag_reg <= 1'b0;
      end_flag_reg <= 1'b0;
      err_flag_reg <= 1'b0;
      BLOCK_O <= 1'b0;
      END_O <= 1'b0;
    end else begin
      BLOCK_O <= blk_hit;
      END_O <= last_word && (agran_reg == `TBD_ZERO);
      if (blk_hit) begin
        blk_flag_reg <= 1'b1;
      end else if (stat_clr && WDATA_I[`TBD_ST_BLOCK]) begin
        blk_flag_reg <= 1'b0;
      end
      if (last_word && (agran_reg == `TBD_ZERO)) begin
        end_flag_reg <= 1'b1;
      end else if (stat_clr && WDATA_I[`TBD_ST_END]) begin
        end_flag_reg <= 1'b0;
      end
      if ((do_define && !def_ok) ||
          (do_start && ((widx == `TBD_IDX_NONE) || !valid_reg[widx] ||
                        (state_reg != S_IDLE)))) begin
        err_flag_reg <= 1'b1;
      end else if (stat_clr && WDATA_I[`TBD_ST_ERR]) begin
        err_flag_reg <= 1'b0;
      end
    end
  end

  always @* begin
    rd_next = `TBD_ZERO;
    case (ADDR_I)
      `TBD_A_CAT: rd_next[15:0] = cat_reg;
      `TBD_A_DIR: rd_next[1:0] = dir_reg;
      `TBD_A_GRAN: rd_next = gran_reg;
      `TBD_A_PTR: rd_next = ptr_reg;
      `TBD_A_OFFS: rd_next = offs_reg;
      `TBD_A_LEN: rd_next = len_reg;
      `TBD_A_MODE: rd_next[1:0] = mode_reg;
      `TBD_A_MSIZE: rd_next = msize_reg;
      `TBD_A_STAT: begin
        rd_next[`TBD_ST_BUSY] = (state_reg != S_IDLE);
        rd_next[`TBD_ST_VALID_LSB + 2:`TBD_ST_VALID_LSB] = valid_reg;
        rd_next[`TBD_ST_BLOCK] = blk_flag_reg;
        rd_next[`TBD_ST_END] = end_flag_reg;
        rd_next[`TBD_ST_ERR] = err_flag_reg;
      end
      `TBD_A_DONE: rd_next = done_reg;
      `TBD_A_TADDR: rd_next = taddr_reg;
      `TBD_A_TDATA: rd_next = tdata_reg;
      `TBD_A_MTEST: rd_next[0] = mtest_reg;
      default: rd_next = `TBD_ZERO;
    endcase
  end

  always @(posedge CLOCK_I) begin
    if (RST_I) begin
      RDATA_O <= `TBD_ZERO;
    end else if (RD_I) begin
      RDATA_O <= rd_next;
    end else begin
      // Read data stand only in the cycle after the strobe
      RDATA_O <= `TBD_ZERO;
    end
  end
endmodule // tbd_dma_setup

// file: tbd_dma_checker.sv
`timescale 1ns/10ps
module tbd_dma_checker #(
  parameter GPU_OPTION = 1'b0
) (
  input wire CLOCK_I,
  input wire RST_I,
  input wire RD_I,
  input wire [31:0] RDATA_O,
  input wire BMEM_RE_O,
  input wire BMEM_WE_O,
  input wire [31:0] BMEM_WDATA_O,
  input wire [31:0] BMEM_RDATA_I,
  input wire HOST_RE_O,
  input wire HOST_WE_O,
  input wire [31:0] HOST_WDATA_O,
  input wire [31:0] HOST_RDATA_I,
  input wire GPU_SEL_O,
  input wire BUSY_O,
  input wire BLOCK_O,
  input wire END_O
);
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);
  sequence s_host_word;
    HOST_RE_O ##2 BMEM_WE_O;
  endsequence
  sequence s_end_alone;
    !BLOCK_O ##1 !END_O;
  endsequence
  a_rdata_idle: assert property (!$past(RD_I) |-> RDATA_O == 32'h0000_0000)
    else $error("read data not idle");
  a_h2b_order: assert property (HOST_RE_O |-> s_host_word)
    else $error("host read not followed by board write");
  a_h2b_data: assert property (BMEM_WE_O && $past(HOST_RE_O, 2) |->
    BMEM_WDATA_O == $past(HOST_RDATA_I))
    else $error("board write data wrong");
  a_b2h_order: assert property (HOST_WE_O |-> $past(BMEM_RE_O, 2))
    else $error("host write without board read");
  a_b2h_data: assert property (HOST_WE_O |-> HOST_WDATA_O == $past(BMEM_RDATA_I))
    else $error("host write data wrong");
  a_event_after_write: assert property ((BLOCK_O || END_O) |->
    $past(HOST_WE_O || BMEM_WE_O))
    else $error("event without a write");
  a_end_alone: assert property (END_O |-> s_end_alone)
    else $error("end pulse malformed");
  a_end_drops_busy: assert property (END_O |-> ##[1:2] !BUSY_O)
    else $error("busy stays after end");
  a_no_gpu_path: assert property (GPU_OPTION != 0 || !GPU_SEL_O)
    else $error("gpu path without option");
  a_host_in_busy: assert property ((HOST_RE_O || HOST_WE_O) |-> ##[0:1] BUSY_O)
    else $error("host access outside transfer");
endmodule // tbd_dma_checker

// file: tbd_mem_model.sv
`timescale 1ns/10ps
module tbd_mem_model (
  input wire clk_i,
  input wire [31:0] bmem_addr_i,
  input wire bmem_re_i,
  input wire bmem_we_i,
  input wire [31:0] bmem_wdata_i,
  output reg [31:0] bmem_rdata_o,
  input wire [31:0] host_addr_i,
  input wire host_re_i,
  input wire host_we_i,
  input wire [31:0] host_wdata_i,
  output reg [31:0] host_rdata_o
);
  reg [31:0] bmem [0:2047];
  reg [31:0] hmem [0:2047];
  initial begin
    bmem_rdata_o = 32'h0000_0000;
    host_rdata_o = 32'h0000_0000;
  end
  // Idle cycles show the inverse so stale data never passes
  always @(posedge clk_i) begin
    bmem_rdata_o <= bmem_re_i ? bmem[bmem_addr_i[12:2]] : ~bmem_rdata_o;
    host_rdata_o <= host_re_i ? hmem[host_addr_i[12:2]] : ~host_rdata_o;
    if (bmem_we_i) begin
      bmem[bmem_addr_i[12:2]] <= bmem_wdata_i;
    end
    if (host_we_i) begin
      hmem[host_addr_i[12:2]] <= host_wdata_i;
    end
  end
endmodule // tbd_mem_model

// file: tb_top.sv
`timescale 1ns/10ps
`include "tbd_defs.vh"
module tb_top;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg [19:0] addr = 20'h0_0000;
  reg [31:0] wdata = 32'h0000_0000;
  reg wr_s = 1'b0;
  reg rd_s = 1'b0;
  wire [31:0] rdata, bm_addr, bm_wdata, bm_rdata, h_addr, h_wdata, h_rdata;
  wire bm_re, bm_we, h_re, h_we, gpu_sel, busy, blk, fin;
  integer failures = 0;
  integer checked = 0;
  integer n_blk = 0;
  integer n_end = 0;
  integer k, m, c, g;
  reg [31:0] d;
  reg [31:0] exp_b [0:2047];
  reg [31:0] exp_h [0:2047];
  reg [31:0] grans [0:3];
  initial begin
    forever #10 clk = ~clk;
  end
  tbd_dma_setup i_dut (.CLOCK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr_s), .RD_I(rd_s), .RDATA_O(rdata), .BMEM_ADDR_O(bm_addr), .BMEM_RE_O(bm_re),
    .BMEM_WE_O(bm_we), .BMEM_WDATA_O(bm_wdata), .BMEM_RDATA_I(bm_rdata),
    .HOST_ADDR_O(h_addr), .HOST_RE_O(h_re), .HOST_WE_O(h_we), .HOST_WDATA_O(h_wdata),
    .HOST_RDATA_I(h_rdata), .GPU_SEL_O(gpu_sel), .BUSY_O(busy), .BLOCK_O(blk), .END_O(fin));
  tbd_mem_model i_mem (.clk_i(clk), .bmem_addr_i(bm_addr), .bmem_re_i(bm_re),
    .bmem_we_i(bm_we), .bmem_wdata_i(bm_wdata), .bmem_rdata_o(bm_rdata),
    .host_addr_i(h_addr), .host_re_i(h_re), .host_we_i(h_we), .host_wdata_i(h_wdata),
    .host_rdata_o(h_rdata));
  always @(posedge clk) begin
    if (blk === 1'b1) begin
      n_blk <= n_blk + 1;
    end
    if (fin === 1'b1) begin
      n_end <= n_end + 1;
    end
  end
  task test_done;
    begin
      $display("checked=%0d failures=%0d", checked, failures);
      if (failures == 0 && checked > 0) begin
        $display("STATUS OK");
      end else begin
        $display("STATUS NOT OK");
      end
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task wr(input [19:0] a, input [31:0] v);
    begin
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
    end
  endtask
  task rd(input [19:0] a);
    begin
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      #1;
      d = rdata;
    end
  endtask
  // Host pointer fixed on a page boundary
  task define(input [31:0] cat, dir, gran, offs, len, input ok);
    begin
      wr(`TBD_A_CAT, cat);
      wr(`TBD_A_DIR, dir);
      wr(`TBD_A_GRAN, gran);
      wr(`TBD_A_PTR, 32'h0000_1000);
      wr(`TBD_A_OFFS, offs);
      wr(`TBD_A_LEN, len);
      wr(`TBD_A_CMD, 32'h0000_0001);
      rd(`TBD_A_STAT);
      chk({31'h0, d[11]}, {31'h0, !ok});
      if (ok) begin
        chk({31'h0, d[cat / 1000 + 3]}, 32'h0000_0001);
      end
      wr(`TBD_A_STAT, 32'h0000_0b00);
    end
  endtask
  task run(input [31:0] dir, gran, offs, len);
    begin
      n_blk = 0;
      n_end = 0;
      wr(`TBD_A_CMD, 32'h0000_0002);
      repeat (3) @(posedge clk);
      for (k = 0; k < 3000 && busy !== 1'b0; k = k + 1) begin
        @(posedge clk);
      end
      if (k == 3000) begin
        failures = failures + 1;
        test_done;
      end
      chk(n_blk, gran ? len / gran : 0);
      chk(n_end, gran ? 0 : 1);
      rd(`TBD_A_STAT);
      chk(d[9:4], gran ? 6'h10 : 6'h20);
      wr(`TBD_A_STAT, 32'h0000_0b00);
      for (k = 0; k < len / 4; k = k + 1) begin
        if (dir == 1) begin
          chk(i_mem.hmem[1024 + k], exp_b[offs / 4 + k]);
        end else begin
          chk(i_mem.bmem[offs / 4 + k], exp_h[1024 + k]);
          exp_b[offs / 4 + k] = exp_h[1024 + k];
        end
      end
    end
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    failures = failures + 1;
    test_done;
  end
  initial begin
    d = $urandom(69);
    for (k = 0; k < 2048; k = k + 1) begin
      exp_b[k] = $urandom;
      exp_h[k] = $urandom;
      i_mem.bmem[k] = exp_b[k];
      i_mem.hmem[k] = exp_h[k];
    end
    grans[0] = 32'h0000_0010;
    grans[1] = 32'h0000_0018;
    grans[2] = 32'h0000_0800;
    grans[3] = 32'h0000_2000;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd(20'h0_0040);
    chk(d, 32'h0000_0000);
    // Memory size must be set first: test mode locks it
    wr(`TBD_A_MSIZE, 32'h0000_0100);
    wr(`TBD_A_MTEST, 32'h0000_0001);
    rd(`TBD_A_MTEST);
    chk(d, 32'h0000_0001);
    wr(`TBD_A_MODE, 32'h0000_0001);
    rd(`TBD_A_MODE);
    chk(d, 32'h0000_0000);
    wr(`TBD_A_MSIZE, 32'h0000_0004);
    rd(`TBD_A_MSIZE);
    chk(d, 32'h0000_0100);
    exp_b[32] = $urandom;
    wr(`TBD_A_TADDR, 32'h0000_0080);
    wr(`TBD_A_TDATA, exp_b[32]);
    wr(`TBD_A_TADDR, 32'h0000_0080);
    repeat (3) @(posedge clk);
    rd(`TBD_A_TDATA);
    chk(d, exp_b[32]);
    chk(i_mem.bmem[32], exp_b[32]);
    // Acquisition mode, yet test mode lets the host write the board
    define(1000, 0, 0, 32'h0000_0040, 32'h0000_0010, 1'b1);
    run(0, 0, 32'h0000_0040, 32'h0000_0010);
    wr(`TBD_A_MTEST, 32'h0000_0000);
    rd(`TBD_A_MTEST);
    chk(d, 32'h0000_0000);
    for (m = 1; m >= 0; m = m - 1) begin
      wr(`TBD_A_MODE, m);
      for (c = 0; c < 4; c = c + 1) begin
        define(1000, c, 16, 32'h0000_0040, 32'h0000_0040, m ? c == 0 : c == 1);
      end
    end
    run(1, 16, 32'h0000_0040, 32'h0000_0040);
    rd(`TBD_A_STAT);
    chk({31'h0, d[4]}, 32'h0000_0000);
    wr(`TBD_A_CMD, 32'h0000_0002);
    rd(`TBD_A_STAT);
    chk({31'h0, d[11]}, 32'h0000_0001);
    wr(`TBD_A_STAT, 32'h0000_0800);
    for (c = 1000; c <= 3000; c = c + 1000) begin
      for (g = 0; g < 4; g = g + 1) begin
        define(c, 1, grans[g], 0, 64, g != 1 && (c == 1000 || g > 1));
      end
    end
    define(1000, 1, 0, 32'h0000_0040, 32'h0000_0200, 1'b0);
    define(2000, 1, 0, 32'h0000_0040, 32'h0000_0020, 1'b1);
    wr(`TBD_A_CMD, 32'h0000_0004);
    wr(`TBD_A_CAT, 32'h0000_0bb8);
    wr(`TBD_A_CMD, 32'h0000_0004);
    rd(`TBD_A_STAT);
    chk({30'h0, d[6:5]}, 32'h0000_0000);
    define(1000, 1, 0, 32'h0000_0080, 32'h0000_0020, 1'b1);
    run(1, 0, 32'h0000_0080, 32'h0000_0020);
    test_done;
  end
endmodule // tb_top
bind tbd_dma_setup tbd_dma_checker #(.GPU_OPTION(GPU_OPTION)) i_chk (
  .CLOCK_I(CLOCK_I), .RST_I(RST_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
  .BMEM_RE_O(BMEM_RE_O), .BMEM_WE_O(BMEM_WE_O), .BMEM_WDATA_O(BMEM_WDATA_O),
  .BMEM_RDATA_I(BMEM_RDATA_I), .HOST_RE_O(HOST_RE_O), .HOST_WE_O(HOST_WE_O),
  .HOST_WDATA_O(HOST_WDATA_O), .HOST_RDATA_I(HOST_RDATA_I), .GPU_SEL_O(GPU_SEL_O),
  .BUSY_O(BUSY_O), .BLOCK_O(BLOCK_O), .END_O(END_O));
